/* File: design/mvcf_defs.vh */
`ifndef MVCF_DEFS_VH
`define MVCF_DEFS_VH
// Widths and reset values of the scan logic
`define MVCF_CH_W      3
`define MVCF_DATA_W    8
`define MVCF_CH_LAST   3'h7
`define MVCF_CH_RST    3'h0
`define MVCF_DATA_RST  8'h00
`endif

/* File: design/mvcf_digital_comparator.v */
`include "mvcf_defs.vh"
`default_nettype none
module mvcf_digital_comparator #(
	parameter DATA_W = `MVCF_DATA_W
) (
	// Operands
	input  wire [DATA_W-1:0] sample_in,
	input  wire [DATA_W-1:0] stored_in,
	// Result
	output wire              greater_out
);
	// Strict compare; equal results never count as a new maximum
	assign greater_out = (sample_in > stored_in);
endmodule
`default_nettype wire

/* File: design/mvcf_max_finder.v */
`include "mvcf_defs.vh"
`default_nettype none
module mvcf_max_finder #(
	parameter CH_W   = `MVCF_CH_W,
	parameter DATA_W = `MVCF_DATA_W
) (
	// Clock and reset
	input  wire              mclk_in,
	input  wire              rst_in,
	// Converter side
	input  wire              conv_done_in,
	input  wire [DATA_W-1:0] conv_data_in,
	// Multiplexer select and display index
	output wire [CH_W-1:0]   mux_sel_out,
	output wire [CH_W-1:0]   winner_out
);

	// Channel counter and its next value
	reg  [CH_W-1:0]   chan_q;
	reg  [CH_W-1:0]   chan_d;

	// Held maximum and its next value
	reg  [DATA_W-1:0] best_q;
	reg  [DATA_W-1:0] best_d;

	// Best channel seen so far, carried across scans
	reg  [CH_W-1:0]   temp_win_q;
	reg  [CH_W-1:0]   temp_win_d;

	// Index shown to the display driver
	reg  [CH_W-1:0]   out_win_q;
	reg  [CH_W-1:0]   out_win_d;

	// Decoded strobes of the current cycle
	wire              greater;
	wire              at_winner;
	wire              new_max;
	wire              load;
	wire              scan_end;

	// Last channel of a scan is the all-ones count, whatever the width
	function is_last;
		input [CH_W-1:0] chan;
		begin
			is_last = (chan == {CH_W{1'b1}});
		end
	endfunction

	// Two channel indices name the same input
	function same_chan;
		input [CH_W-1:0] chan_a;
		input [CH_W-1:0] chan_b;
		begin
			same_chan = (chan_a == chan_b);
		end
	endfunction

	// Next select; the natural rollover of the width gives the wrap
	function [CH_W-1:0] next_chan;
		input [CH_W-1:0] chan;
		begin
			next_chan = chan + {{(CH_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// Comparator sees the live result against the held maximum
	mvcf_digital_comparator #(
		.DATA_W      (DATA_W)
	) mvcf_digital_comparator_i (
		.sample_in   (conv_data_in),
		.stored_in   (best_q),
		.greater_out (greater)
	);

	// Counter parked on the latched winner forces a reload;
	// without it a falling old maximum would never be replaced
	assign at_winner = same_chan(chan_q, temp_win_q);

	// Genuine new maximum, only counted while the result is valid
	assign new_max   = conv_done_in & greater;

	// Qualified with done so a glitching compare never loads
	assign load      = new_max | (conv_done_in & at_winner);

	// Done on the last channel closes the scan
	assign scan_end  = conv_done_in & is_last(chan_q);

	// Counter advance; the done pulse is same-clock logic, no sync
	always @* begin
		chan_d = chan_q;
		if (conv_done_in) begin
			chan_d = next_chan(chan_q);
		end
	end

	// Buffer next value; the result is only taken on a load,
	// so an idle converter bus can never disturb the maximum
	always @* begin
		best_d = best_q;
		if (load) begin
			best_d = conv_data_in;
		end
	end

	// Temporary winner follows genuine new maxima only; a
	// forced reload keeps the index so the channel stays armed
	always @* begin
		temp_win_d = temp_win_q;
		if (new_max) begin
			temp_win_d = chan_q;
		end
	end

	// Output index, refreshed at each wrap; a win on the last
	// channel is taken directly so it is not one loop late
	always @* begin
		out_win_d = out_win_q;
		if (scan_end) begin
			if (greater) begin
				out_win_d = chan_q;
			end else begin
				out_win_d = temp_win_q;
			end
		end
	end

	// Channel counter register
	always @(posedge mclk_in) begin
		if (rst_in) begin
			chan_q <= `MVCF_CH_RST;
		end else begin
			chan_q <= chan_d;
		end
	end

	// Winner buffer register
	always @(posedge mclk_in) begin
		if (rst_in) begin
			best_q <= `MVCF_DATA_RST;
		end else begin
			best_q <= best_d;
		end
	end

	// Temporary winner register
	always @(posedge mclk_in) begin
		if (rst_in) begin
			temp_win_q <= `MVCF_CH_RST;
		end else begin
			temp_win_q <= temp_win_d;
		end
	end

	// Output winner register; steady between scan ends, so the
	// display never shows a half-finished scan
	always @(posedge mclk_in) begin
		if (rst_in) begin
			out_win_q <= `MVCF_CH_RST;
		end else begin
			out_win_q <= out_win_d;
		end
	end

	// Both outputs come straight from registers
	assign mux_sel_out = chan_q;
	assign winner_out  = out_win_q;

	// Limitation: the temporary winner is not cleared between
	// scans; a stale index is harmless because the forced reload
	// lets any other channel above the reloaded value take over.
	// Trade-off: strict compare keeps the first of two equal
	// channels, so ties do not make the display flicker.
	// Hazard: a done pulse held high for several cycles counts
	// once per cycle, so the converter must pulse for one clock.
	// Limitation: up to two full scans, plus the rest of the current one,
	// pass after a voltage change before the output can follow it.
endmodule
`default_nettype wire

/* File: dv/mvcf_asserts.sv */
`default_nettype none
module mvcf_asserts (
	input wire logic       mclk_in, rst_in, conv_done_in,
	input wire logic [2:0] mux_sel_out, winner_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Select steps once per done; index moves only at scan end
	cnt_step_a: assert property (conv_done_in |=> mux_sel_out == $past(mux_sel_out) + 3'h1)
		else $error("step");
	win_load_a: assert property (!$past(rst_in) && $changed(winner_out)
		|-> $past(conv_done_in && mux_sel_out == 3'h7)) else $error("index");
	rst_clr_a: assert property (disable iff (1'b0) rst_in |=> mux_sel_out == 3'h0
		&& winner_out == 3'h0) else $error("reset");
	sel_hold_a: assert property (!conv_done_in |=> $stable(mux_sel_out))
		else $error("select moved");
	wrap_zero_a: assert property (conv_done_in && mux_sel_out == 3'h7
		|=> mux_sel_out == 3'h0) else $error("wrap");
	win_hold_a: assert property (!conv_done_in |=> $stable(winner_out))
		else $error("index moved");
endmodule
bind mvcf_max_finder mvcf_asserts mvcf_asserts_i (.mclk_in, .rst_in, .conv_done_in,
	.mux_sel_out, .winner_out);
`default_nettype wire

/* File: dv/mvcf_adc.sv */
`default_nettype none
module mvcf_adc (
	input wire logic        c_in, f_in,
	input wire logic [2:0]  s_in,
	input wire logic [63:0] v_in,
	output logic            d_out,
	output logic [7:0]      q_out
);
	initial d_out = 1'b0;
	// Result rides with done; bus inverted between pulses, no stale value
	always @(posedge c_in) begin
		d_out <= f_in | !d_out;
		q_out <= (f_in | !d_out) ? v_in[{s_in + d_out, 3'h0} +: 8] : ~q_out;
	end
endmodule
`default_nettype wire

/* File: dv/mvcf_bench.sv */
`default_nettype none
module mvcf_bench;
	timeunit 1ns; timeprecision 1ns;
	logic        c = 0, r = 1, f = 0, d;
	logic [7:0]  q;
	logic [63:0] v = 64'h3c05_2832_1e5a_140a;
	wire  [2:0]  s, w;
	int          bad_count = 0, total_checks = 0, t = 0;
	always #25 c = ~c;
	mvcf_adc mvcf_adc_i (.c_in(c), .f_in(f), .s_in(s), .v_in(v), .d_out(d), .q_out(q));
	mvcf_max_finder mvcf_max_finder_i (.mclk_in(c), .rst_in(r), .conv_done_in(d),
		.conv_data_in(q), .mux_sel_out(s), .winner_out(w));
	task chk(input logic [5:0] a, e);
		total_checks++;
		if (a !== e) begin bad_count++; $display("CHECK FAILED %0t %h %h", $time, a, e); end
	endtask
	task results;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One scan is eight done pulses; a stuck converter ends the run
	task scan(input logic [2:0] e);
		repeat (8) do @(posedge c); while (!d && ++t < 99);
		if (t >= 99) begin bad_count++; results(); end
		#1 chk({w, s}, {e, 3'h0});
	endtask
	// Slow scan, then the old maximum falls while pulses run back to back
	initial begin
		repeat (5) @(posedge c);
		r <= 0;
		#1 chk({w, s}, 6'h00);
		scan(3'h2);
		@(posedge c) v <= 64'h3c05_2832_1e01_550a; f <= 1;
		scan(3'h7);
		scan(3'h1);
		results();
	end
endmodule
`default_nettype wire
